// ===== card_reader_ctrl.sv
// Card reader power, clock, reset and interrupt control
`timescale 1ns/1ps
`include "card_reader_ctrl_defines.svh"

module card_reader_ctrl #(
  parameter int unsigned CNT_256US  = `T_256_US * `CLK_MHZ,
  parameter int unsigned CNT_1024US = `T_1024_US * `CLK_MHZ,
  parameter int unsigned CNT_1MS    = `T_1_MS * `US_PER_MS * `CLK_MHZ,
  parameter int unsigned CNT_256MS  = `T_256_MS * `US_PER_MS * `CLK_MHZ,
  parameter int unsigned CNT_512MS  = `T_512_MS * `US_PER_MS * `CLK_MHZ,
  parameter int unsigned CNT_1024MS = `T_1024_MS * `US_PER_MS * `CLK_MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        reg_space_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        card_removed_i,
  input  wire logic        usb_clk_stopped_i,
  input  wire logic        picture_irq_i,
  input  wire logic        secure_irq_i,
  input  wire logic        dma_irq_i,
  input  wire logic [10:0] eng_event_i,
  input  wire logic        eng_wait_i,
  input  wire logic        xfer_active_i,
  input  wire logic        picture_busy_i,
  input  wire logic        secure_busy_i,
  input  wire logic        dma_busy_i,
  output logic             socket_power_o,
  output logic             pad_3v3_o,
  output logic             soft_reset_o,
  output logic             picture_clk_run_o,
  output logic             secure_clk_run_o,
  output logic             dma_clk_run_o,
  output logic      [2:0]  picture_clk_sel_o,
  output logic      [2:0]  secure_clk_sel_o,
  output logic      [2:0]  dma_clk_sel_o,
  output logic             timeout_o,
  output logic             irq_o
);

  localparam int unsigned CNT_32US = `T_32_US * `CLK_MHZ;
  localparam int unsigned CNT_1US  = `T_1_US * `CLK_MHZ;
  localparam logic [7:0]  PWR_RST  = `RST_PWR_CLK_RST;

  // Pin synchronisers
  logic [1:0] removed_sync_q;
  logic [1:0] clkstop_sync_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      removed_sync_q <= 2'b00;
      clkstop_sync_q <= 2'b00;
    end else begin
      removed_sync_q <= {removed_sync_q[0], card_removed_i};
      clkstop_sync_q <= {clkstop_sync_q[0], usb_clk_stopped_i};
    end
  end

  wire card_removed = removed_sync_q[1];
  wire clk_stopped  = clkstop_sync_q[1];

  // Register decode
  wire ctl_space  = ~reg_space_i;
  wire wr_pwr     = reg_wr_i & ctl_space & (reg_addr_i == `OFS_PWR_CLK_RST);
  wire wr_pic     = reg_wr_i & ctl_space & (reg_addr_i == `OFS_PIC_CLK_SEL);
  wire wr_sec     = reg_wr_i & ctl_space & (reg_addr_i == `OFS_SEC_CLK_SEL);
  wire wr_dma     = reg_wr_i & ctl_space & (reg_addr_i == `OFS_DMA_CLK_SEL);
  wire wr_ien     = reg_wr_i & ctl_space & (reg_addr_i == `OFS_TOP_IRQ_EN);
  wire wr_to      = reg_wr_i & ctl_space & (reg_addr_i == `OFS_TIMEOUT_SEL);
  wire wr_flags   = reg_wr_i & reg_space_i & (reg_addr_i == `OFS_ENG_FLAGS);
  wire wr_setting = reg_wr_i & reg_space_i & (reg_addr_i == `OFS_ENG_SETTING);

  // Control register state
  logic       power_q, pad_3v3_q, gate_en_q, soft_rst_q;
  logic [2:0] pic_sel_q, sec_sel_q, dma_sel_q, to_sel_q;
  logic [7:0] irq_en_q;
  logic [`ENG_EVT_W-1:0] eng_mask_q, eng_flags_q;
  logic [1:0] wait_sel_q;

  wire power_d = card_removed ? 1'b0 :
                 wr_pwr ? reg_wdata_i[`BIT_POWER_ON] : power_q;
  wire soft_rst_d = wr_pwr & ~reg_wdata_i[`BIT_SOFT_RST_N];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_q    <= PWR_RST[`BIT_POWER_ON];
      pad_3v3_q  <= PWR_RST[`BIT_PAD_3V3];
      gate_en_q  <= PWR_RST[`BIT_GATE_EN];
      soft_rst_q <= 1'b0;
    end else begin
      power_q    <= power_d;
      soft_rst_q <= soft_rst_d;
      if (wr_pwr) begin
        pad_3v3_q <= reg_wdata_i[`BIT_PAD_3V3];
        gate_en_q <= reg_wdata_i[`BIT_GATE_EN];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pic_sel_q <= `RST_PIC_CLK_SEL;
      sec_sel_q <= `RST_SEC_CLK_SEL;
      dma_sel_q <= `RST_DMA_CLK_SEL;
      to_sel_q  <= `RST_TIMEOUT_SEL;
      irq_en_q  <= 8'h00;
    end else begin
      if (wr_pic) pic_sel_q <= reg_wdata_i[2:0];
      if (wr_sec) sec_sel_q <= reg_wdata_i[2:0];
      if (wr_dma) dma_sel_q <= reg_wdata_i[2:0];
      if (wr_to)  to_sel_q  <= reg_wdata_i[2:0];
      if (wr_ien) irq_en_q  <= reg_wdata_i[7:0] & `TOP_IRQ_MASK;
    end
  end

  // Engine setting register and event flags
  logic wait_expired;
  wire [`ENG_EVT_W-1:0] eng_set =
    eng_event_i | {{(`ENG_EVT_W-1){1'b0}}, wait_expired};
  wire [`ENG_EVT_W-1:0] eng_clr =
    wr_flags ? reg_wdata_i[`ENG_EVT_W-1:0] : '0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      eng_mask_q  <= '0;
      wait_sel_q  <= 2'b00;
      eng_flags_q <= '0;
    end else begin
      if (wr_setting) begin
        eng_mask_q <= reg_wdata_i[`ENG_MASK_MSB:0];
        wait_sel_q <= reg_wdata_i[`ENG_WAIT_MSB:`ENG_WAIT_LSB];
      end
      eng_flags_q <= (eng_flags_q & ~eng_clr) | eng_set;
    end
  end

  // Engine interrupt only from enabled flags
  wire eng_irq = |(eng_flags_q & eng_mask_q);

  // Top status and interrupt output
  wire [7:0] top_status = {1'b0, clk_stopped, eng_irq, dma_irq_i,
                           1'b0, secure_irq_i, 1'b0, picture_irq_i};
  wire irq_d = |(top_status & irq_en_q);

  // Wait-for-controller timer
  logic [`CNT_W-1:0] wait_cnt_q;
  logic [`CNT_W-1:0] wait_lim;
  always_comb begin
    case (card_reader_ctrl_pkg::wait_sel_t'(wait_sel_q))
      card_reader_ctrl_pkg::WAIT_1US:    wait_lim = `CNT_W'(CNT_1US);
      card_reader_ctrl_pkg::WAIT_1MS:    wait_lim = `CNT_W'(CNT_1MS);
      card_reader_ctrl_pkg::WAIT_1024MS: wait_lim = `CNT_W'(CNT_1024MS);
      default:                           wait_lim = '0;
    endcase
  end
  wire wait_run = eng_wait_i & (wait_lim != '0);
  assign wait_expired = wait_run & (wait_cnt_q >= wait_lim - `CNT_W'(1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt_q <= '0;
    end else if (!wait_run || wait_expired) begin
      wait_cnt_q <= '0;
    end else begin
      wait_cnt_q <= wait_cnt_q + `CNT_W'(1);
    end
  end

  // Transfer time-out timer
  logic [`CNT_W-1:0] to_cnt_q;
  logic [`CNT_W-1:0] to_lim;
  logic              to_done_q;
  always_comb begin
    case (card_reader_ctrl_pkg::timeout_sel_t'(to_sel_q))
      card_reader_ctrl_pkg::TO_32US:   to_lim = `CNT_W'(CNT_32US);
      card_reader_ctrl_pkg::TO_256US:  to_lim = `CNT_W'(CNT_256US);
      card_reader_ctrl_pkg::TO_1024US: to_lim = `CNT_W'(CNT_1024US);
      card_reader_ctrl_pkg::TO_256MS:  to_lim = `CNT_W'(CNT_256MS);
      card_reader_ctrl_pkg::TO_512MS:  to_lim = `CNT_W'(CNT_512MS);
      card_reader_ctrl_pkg::TO_1024MS: to_lim = `CNT_W'(CNT_1024MS);
      default:                         to_lim = '0;
    endcase
  end
  wire to_run = xfer_active_i & (to_lim != '0) & ~to_done_q;
  wire to_hit = to_run & (to_cnt_q >= to_lim - `CNT_W'(1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      to_cnt_q  <= '0;
      to_done_q <= 1'b0;
    end else if (!xfer_active_i) begin
      to_cnt_q  <= '0;
      to_done_q <= 1'b0;
    end else if (to_run) begin
      to_cnt_q  <= to_hit ? '0 : to_cnt_q + `CNT_W'(1);
      to_done_q <= to_hit;
    end
  end

  // Read data
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (!reg_rd_i) begin
      rdata_d = 32'h0000_0000;
    end else if (reg_space_i && reg_addr_i == `OFS_ENG_FLAGS) begin
      rdata_d[`ENG_EVT_W-1:0] = eng_flags_q;
    end else if (reg_space_i && reg_addr_i == `OFS_ENG_SETTING) begin
      rdata_d[`ENG_MASK_MSB:0] = eng_mask_q;
      rdata_d[`ENG_WAIT_MSB:`ENG_WAIT_LSB] = wait_sel_q;
    end else if (reg_space_i) begin
      rdata_d = 32'h0000_0000;
    end else if (reg_addr_i == `OFS_PWR_CLK_RST) begin
      rdata_d[`BIT_POWER_ON]   = power_q;
      rdata_d[`BIT_PAD_3V3]    = pad_3v3_q;
      rdata_d[`BIT_GATE_EN]    = gate_en_q;
      rdata_d[`BIT_SOFT_RST_N] = ~soft_rst_q;
    end else if (reg_addr_i == `OFS_PIC_CLK_SEL) begin
      rdata_d[2:0] = pic_sel_q;
    end else if (reg_addr_i == `OFS_SEC_CLK_SEL) begin
      rdata_d[2:0] = sec_sel_q;
    end else if (reg_addr_i == `OFS_DMA_CLK_SEL) begin
      rdata_d[2:0] = dma_sel_q;
    end else if (reg_addr_i == `OFS_TOP_IRQ_EN) begin
      rdata_d[7:0] = irq_en_q;
    end else if (reg_addr_i == `OFS_TOP_IRQ_STAT) begin
      rdata_d[7:0] = top_status;
    end else if (reg_addr_i == `OFS_TIMEOUT_SEL) begin
      rdata_d[2:0] = to_sel_q;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o       <= 32'h0000_0000;
      irq_o             <= 1'b0;
      timeout_o         <= 1'b0;
      picture_clk_run_o <= 1'b1;
      secure_clk_run_o  <= 1'b1;
      dma_clk_run_o     <= 1'b1;
    end else begin
      reg_rdata_o       <= rdata_d;
      irq_o             <= irq_d;
      timeout_o         <= to_hit;
      picture_clk_run_o <= ~gate_en_q | picture_busy_i;
      secure_clk_run_o  <= ~gate_en_q | secure_busy_i;
      dma_clk_run_o     <= ~gate_en_q | dma_busy_i;
    end
  end

  assign socket_power_o    = power_q;
  assign pad_3v3_o         = pad_3v3_q;
  assign soft_reset_o      = soft_rst_q;
  assign picture_clk_sel_o = pic_sel_q;
  assign secure_clk_sel_o  = sec_sel_q;
  assign dma_clk_sel_o     = dma_sel_q;

  // Helper count of cycles in an unbroken 1 us wait, saturating at 255, read by the wait check
  logic [7:0] wait_hold_q;
  wire        hold_run = eng_wait_i &
                         (wait_sel_q == card_reader_ctrl_pkg::WAIT_1US);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_hold_q <= 8'h00;
    end else if (!hold_run) begin
      wait_hold_q <= 8'h00;
    end else if (wait_hold_q != 8'hff) begin
      wait_hold_q <= wait_hold_q + 8'h01;
    end
  end

  // Checks
  a_power_removal: assert property (@(posedge clk_i)
    disable iff (rst_i) card_removed |=> !socket_power_o)
    else $error("Socket power stayed on after removal");

  a_soft_reset_pulse: assert property (@(posedge clk_i)
    disable iff (rst_i) (soft_reset_o && !wr_pwr) |=> !soft_reset_o)
    else $error("Soft reset did not release");

  a_soft_reset_write: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (wr_pwr && !reg_wdata_i[`BIT_SOFT_RST_N]) |=> soft_reset_o)
    else $error("Soft reset write ignored");

  a_wrong_src_mask: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (eng_flags_q == (`ENG_EVT_W'(1) << `EVT_WRONG_SRC))
      && !eng_mask_q[`EVT_WRONG_SRC] |-> !eng_irq)
    else $error("Masked wrong-source event raised interrupt");

  a_flag_set_wins: assert property (@(posedge clk_i)
    disable iff (rst_i) eng_event_i[1] |=> eng_flags_q[1])
    else $error("Engine event lost");

  a_flag_w1c: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (wr_flags && reg_wdata_i[2] && !eng_event_i[2]) |=> !eng_flags_q[2])
    else $error("Write one did not clear flag");

  a_irq_out: assert property (@(posedge clk_i)
    disable iff (rst_i) ##1 irq_o == $past(|(top_status & irq_en_q)))
    else $error("Interrupt output mismatch");

  a_irq_en_gate: assert property (@(posedge clk_i)
    disable iff (rst_i) (irq_en_q == 8'h00) |=> !irq_o)
    else $error("Interrupt raised with all enables off");

  a_wait_timeout: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (hold_run && wait_hold_q == 8'(CNT_1US - 1))
      |=> eng_flags_q[`EVT_WAIT_TIMEOUT])
    else $error("Wait timeout not flagged after 1 us");

  a_gate_run: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !gate_en_q |=> picture_clk_run_o && secure_clk_run_o && dma_clk_run_o)
    else $error("Clock stopped while gating disabled");

  a_timeout_pulse: assert property (@(posedge clk_i)
    disable iff (rst_i) timeout_o |=> !timeout_o)
    else $error("Time-out longer than one cycle");

  c_soft_reset: cover property (@(posedge clk_i) disable iff (rst_i)
    soft_reset_o ##1 !soft_reset_o);
  c_removal: cover property (@(posedge clk_i) disable iff (rst_i)
    socket_power_o ##1 !socket_power_o);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
  c_timeout: cover property (@(posedge clk_i) disable iff (rst_i) timeout_o);

endmodule

// ===== card_reader_ctrl_defines.svh
// Offsets, field positions, reset values and timing constants
`ifndef CARD_READER_CTRL_DEFINES_SVH
`define CARD_READER_CTRL_DEFINES_SVH

// Control space byte offsets
`define OFS_PWR_CLK_RST      8'h02
`define OFS_PIC_CLK_SEL      8'h03
`define OFS_SEC_CLK_SEL      8'h05
`define OFS_DMA_CLK_SEL      8'h07
`define OFS_TOP_IRQ_EN       8'h08
`define OFS_TOP_IRQ_STAT     8'h09
`define OFS_TIMEOUT_SEL      8'h0a
// Engine space byte offsets
`define OFS_ENG_FLAGS        8'h0c
`define OFS_ENG_SETTING      8'h10

// Control register fields
`define BIT_POWER_ON         5
`define BIT_PAD_3V3          4
`define BIT_GATE_EN          1
`define BIT_SOFT_RST_N       0
`define RST_PWR_CLK_RST      8'h11
`define RST_PIC_CLK_SEL      3'h6
`define RST_SEC_CLK_SEL      3'h3
`define RST_DMA_CLK_SEL      3'h0
`define RST_TIMEOUT_SEL      3'h0

// Top interrupt bits
`define BIT_IRQ_CLK_STOP     6
`define BIT_IRQ_ENGINE       5
`define BIT_IRQ_DMA          4
`define BIT_IRQ_SECURE       2
`define BIT_IRQ_PICTURE      0
`define TOP_IRQ_MASK         8'h75

// Engine setting fields
`define ENG_EVT_W            11
`define ENG_MASK_MSB         10
`define ENG_WAIT_LSB         16
`define ENG_WAIT_MSB         17
`define EVT_WRONG_SRC        5
`define EVT_WAIT_TIMEOUT     0

// Timing
`define CLK_MHZ              100
`define T_32_US              32
`define T_256_US             256
`define T_1024_US            1024
`define T_1_US               1
`define T_1_MS               1
`define T_256_MS             256
`define T_512_MS             512
`define T_1024_MS            1024
`define US_PER_MS            1000
`define CNT_W                27

`endif

// ===== card_reader_ctrl_pkg.sv
// Types shared by the card reader control block
package card_reader_ctrl_pkg;

  typedef enum logic [2:0] {
    TO_OFF     = 3'b000,
    TO_32US    = 3'b001,
    TO_256US   = 3'b010,
    TO_1024US  = 3'b011,
    TO_256MS   = 3'b100,
    TO_512MS   = 3'b101,
    TO_1024MS  = 3'b110,
    TO_RSVD    = 3'b111
  } timeout_sel_t;

  typedef enum logic [1:0] {
    WAIT_NEVER  = 2'b00,
    WAIT_1US    = 2'b01,
    WAIT_1MS    = 2'b10,
    WAIT_1024MS = 2'b11
  } wait_sel_t;

endpackage

// ===== card_reader_far_side.sv
// Far-side model of the card controllers, DMA engine and descriptor engine
`timescale 1ns/1ps

module card_reader_far_side (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        soft_reset_i,
  input  wire logic        slow_i,
  input  wire logic [2:0]  raise_i,
  input  wire logic [2:0]  busy_req_i,
  input  wire logic [10:0] event_req_i,
  input  wire logic        wait_req_i,
  input  wire logic        xfer_req_i,
  output logic      [2:0]  irq_o,
  output logic      [2:0]  busy_o,
  output logic      [10:0] event_o,
  output logic             wait_o,
  output logic             xfer_o
);
  logic [2:0] busy_q;

  // Controllers hold their request until soft reset clears it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o   <= 3'h0;
      busy_q  <= 3'h0;
      busy_o  <= 3'h0;
      event_o <= 11'h000;
      wait_o  <= 1'b0;
      xfer_o  <= 1'b0;
    end else begin
      irq_o   <= soft_reset_i ? 3'h0 : (irq_o | raise_i);
      busy_q  <= busy_req_i;
      busy_o  <= slow_i ? busy_q : busy_req_i;
      event_o <= event_req_i;
      wait_o  <= wait_req_i;
      xfer_o  <= xfer_req_i;
    end
  end
endmodule

// ===== card_reader_control_and_irq_tb.sv
// Self-checking testbench for the card reader control block
`timescale 1ns/1ps

module card_reader_control_and_irq_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, reg_space_i = 1'b0;
  logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_seen = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
  logic        card_removed_i = 1'b0, usb_clk_stopped_i = 1'b0;
  logic        slow = 1'b0, wait_req = 1'b0, xfer_req = 1'b0;
  logic [2:0]  raise = 3'h0, busy_req = 3'h0, irq_w, busy_w;
  logic [10:0] event_req = 11'h000, eng_event;
  logic        eng_wait, xfer_act, soft_reset_o, timeout_o, irq_o;
  logic        socket_power_o, pad_3v3_o;
  logic        pic_run, sec_run, dma_run;
  logic [2:0]  pic_sel, sec_sel, dma_sel;
  logic [31:0] exp_q[$];
  int          failures = 0, checks = 0, sr_cnt = 0, to_cnt = 0;
  int          n, c;
  int          tn[6] = '{3200, 20, 30, 45, 50, 60};
  logic [7:0]  ra[9] = '{8'h02, 8'h03, 8'h05, 8'h07, 8'h08, 8'h09,
                         8'h0a, 8'h04, 8'h0b};
  logic [31:0] re[9] = '{32'h11, 32'h06, 32'h03, 32'h0, 32'h0, 32'h0,
                         32'h0, 32'h0, 32'h0};

  card_reader_ctrl #(.CNT_256US(20), .CNT_1024US(30), .CNT_1MS(40),
    .CNT_256MS(45), .CNT_512MS(50), .CNT_1024MS(60)) card_reader_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .reg_space_i(reg_space_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .card_removed_i(card_removed_i), .usb_clk_stopped_i(usb_clk_stopped_i),
    .picture_irq_i(irq_w[0]), .secure_irq_i(irq_w[1]),
    .dma_irq_i(irq_w[2]), .eng_event_i(eng_event), .eng_wait_i(eng_wait),
    .xfer_active_i(xfer_act), .picture_busy_i(busy_w[0]),
    .secure_busy_i(busy_w[1]), .dma_busy_i(busy_w[2]),
    .socket_power_o(socket_power_o), .pad_3v3_o(pad_3v3_o),
    .soft_reset_o(soft_reset_o), .picture_clk_run_o(pic_run),
    .secure_clk_run_o(sec_run), .dma_clk_run_o(dma_run),
    .picture_clk_sel_o(pic_sel), .secure_clk_sel_o(sec_sel),
    .dma_clk_sel_o(dma_sel), .timeout_o(timeout_o), .irq_o(irq_o));

  card_reader_far_side card_reader_far_side_i (
    .clk_i(clk_i), .rst_i(rst_i), .soft_reset_i(soft_reset_o),
    .slow_i(slow), .raise_i(raise), .busy_req_i(busy_req),
    .event_req_i(event_req), .wait_req_i(wait_req), .xfer_req_i(xfer_req),
    .irq_o(irq_w), .busy_o(busy_w), .event_o(eng_event),
    .wait_o(eng_wait), .xfer_o(xfer_act));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic give_verdict;
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] e);
    checks++;
    if (seen !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic wr(input logic s, input logic [7:0] a, input logic [31:0] d);
    reg_space_i = s;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic s, input logic [7:0] a, input logic [31:0] e);
    reg_space_i = s;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic pulse_event(input logic [10:0] ev);
    event_req = ev;
    @(negedge clk_i);
    event_req = 11'h000;
    repeat (3) @(negedge clk_i);
  endtask

  // Read data is compared one cycle after the strobe edge
  always @(posedge clk_i) begin
    rd_seen <= reg_rd_i;
    sr_cnt <= sr_cnt + int'(soft_reset_o);
    to_cnt <= to_cnt + int'(timeout_o);
  end
  always @(negedge clk_i) begin
    if (rd_seen) check("read data", reg_rdata_o, exp_q.pop_front());
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h9281));
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    for (int i = 0; i < 9; i++) begin
      rd(1'b0, ra[i], re[i]);
    end
    rd(1'b1, 8'h10, 32'h0);
    check("selects", {pic_sel, sec_sel, dma_sel}, 9'h198);
    check("power pins", {socket_power_o, pad_3v3_o}, 2'b01);
    for (int k = 0; k < 7; k++) begin
      if (k != 3) wr(1'b0, 8'h03, ($urandom & 32'hffff_fff8) | k);
      wr(1'b0, 8'h05, ($urandom & 32'hffff_fff8) | k);
      wr(1'b0, 8'h07, k & 2);
      if (k != 3) rd(1'b0, 8'h03, k);
      rd(1'b0, 8'h05, k);
      rd(1'b0, 8'h07, k & 2);
      check("secure select", sec_sel, k);
      check("dma select", dma_sel, k & 2);
    end
    wr(1'b0, 8'h08, 32'hff);
    rd(1'b0, 8'h08, 32'h75);
    wr(1'b0, 8'h08, 32'h0);
    wr(1'b0, 8'h09, 32'hff);
    rd(1'b0, 8'h09, 32'h0);
    for (int i = 0; i < 3; i++) begin
      raise = 3'h1 << i;
      @(negedge clk_i);
      raise = 3'h0;
      repeat (3) @(negedge clk_i);
      rd(1'b0, 8'h09, 32'h1 << (2 * i));
      check("irq", irq_o, 1'b0);
      wr(1'b0, 8'h08, (32'h1 << (2 * i)) | ($urandom & 32'h8a));
      check("irq", irq_o, 1'b1);
      n = sr_cnt;
      wr(1'b0, 8'h02, 32'h10);
      repeat (2) @(negedge clk_i);
      check("soft reset pulses", sr_cnt - n, 32'h1);
      rd(1'b0, 8'h02, 32'h11);
      rd(1'b0, 8'h09, 32'h0);
      check("irq", irq_o, 1'b0);
    end
    wr(1'b0, 8'h08, 32'h20);
    for (int b = 0; b < 11; b++) begin
      wr(1'b1, 8'h10, 32'h1 << b);
      pulse_event(11'h1 << b);
      check("irq", irq_o, 1'b1);
      rd(1'b1, 8'h0c, 32'h1 << b);
      rd(1'b0, 8'h09, 32'h20);
      wr(1'b1, 8'h0c, 32'h1 << b);
      repeat (2) @(negedge clk_i);
      check("irq", irq_o, 1'b0);
    end
    wr(1'b1, 8'h10, 32'hffff_ffdf);
    rd(1'b1, 8'h10, 32'h0003_07df);
    pulse_event(11'h020);
    rd(1'b1, 8'h0c, 32'h20);
    rd(1'b0, 8'h09, 32'h0);
    check("irq", irq_o, 1'b0);
    wr(1'b1, 8'h0c, 32'h20);
    wr(1'b1, 8'h10, 32'h0001_0001);
    wait_req = 1'b1;
    repeat (90) @(negedge clk_i);
    rd(1'b1, 8'h0c, 32'h0);
    repeat (20) @(negedge clk_i);
    rd(1'b1, 8'h0c, 32'h1);
    wait_req = 1'b0;
    rd(1'b0, 8'h09, 32'h20);
    wr(1'b1, 8'h0c, 32'h1);
    for (int k = 1; k < 7; k++) begin
      wr(1'b0, 8'h0a, k);
      n = to_cnt;
      xfer_req = 1'b1;
      c = 0;
      while (timeout_o !== 1'b1 && c < tn[k-1] + 20) begin
        @(negedge clk_i);
        c++;
      end
      check("timeout delay", c >= tn[k-1] - 1 && c <= tn[k-1] + 4, 1);
      if (c >= tn[k-1] + 20) give_verdict();
      repeat (70) @(negedge clk_i);
      check("timeout pulses", to_cnt - n, 32'h1);
      xfer_req = 1'b0;
      repeat (3) @(negedge clk_i);
    end
    for (int k = 0; k < 8; k += 7) begin
      wr(1'b0, 8'h0a, k);
      n = to_cnt;
      xfer_req = 1'b1;
      repeat (100) @(negedge clk_i);
      check("timeout off", to_cnt - n, 32'h0);
      xfer_req = 1'b0;
    end
    wr(1'b0, 8'h02, 32'h21);
    check("power pins", {socket_power_o, pad_3v3_o}, 2'b10);
    card_removed_i = 1'b1;
    repeat (6) @(negedge clk_i);
    check("socket power", socket_power_o, 1'b0);
    rd(1'b0, 8'h02, 32'h01);
    card_removed_i = 1'b0;
    usb_clk_stopped_i = 1'b1;
    repeat (5) @(negedge clk_i);
    rd(1'b0, 8'h09, 32'h40);
    wr(1'b0, 8'h08, 32'h40);
    check("irq", irq_o, 1'b1);
    usb_clk_stopped_i = 1'b0;
    repeat (6) @(negedge clk_i);
    check("irq", irq_o, 1'b0);
    wr(1'b0, 8'h02, 32'h13);
    repeat (3) @(negedge clk_i);
    check("clock run", {pic_run, sec_run, dma_run}, 3'b000);
    slow = 1'b1;
    busy_req = 3'($urandom);
    repeat (5) @(negedge clk_i);
    check("clock run", {dma_run, sec_run, pic_run}, busy_req);
    busy_req = 3'b000;
    wr(1'b0, 8'h02, 32'h11);
    repeat (2) @(negedge clk_i);
    check("clock run", {pic_run, sec_run, dma_run}, 3'b111);
    give_verdict();
  end
endmodule
